// file: src/lefcf_pkg.sv
/*
  Package for the link event and channel filter block: register offsets,
  event bit positions, reset values and the bus and event carriers.
  Assumes a single 200 MHz clock domain and a plain register port.
*/
// How it works
// - Isochronous channel n (0..31) accepted only while filter bit n is one.
// - Filter set by ones at 78h, cleared by ones at 7Ch; both read mask.
// - Event set register at 80h, clear register at 84h, bitwise.
// - Event bit sets on source rising edge, timer bit change or software set-register one.
// - Event bit clears only by writing one to the clear register.
// - Event register read returns events ANDed with the event mask at 88h.
// - Event bits 31, 30 and 28 are reserved and read zero.
// - Event bit 29 has no hardware source; software set and clear only.
// - Bit 27 sets from late-ack triggers only while late-ack enable is one.
// - Bit 26 sets on PHY byte arrival; byte readable in bits 23-16.
// - Bit 25 sets on cycle overrun while acting as cycle master.
// - Cycle overrun clears the cycle master enable, link control bit 21.
// - Bit 24 sets on fatal fault; blocks offending contexts' interrupts.
// - Bit 23 sets when received cycle start mismatches local cycle timer.
// - Bit 22 sets when no cycle start between two new-cycle events.
// - Missed cycle may be set early on a predicted loss.
// - Bit 21 sets whenever seconds counter bit 6 changes.
// - Bit 20 sets whenever cycle index bit 0 toggles.
package lefcf_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_FILTER_SET = 8'h78;
  localparam logic [7:0] OFS_FILTER_CLR = 8'h7C;
  localparam logic [7:0] OFS_EVENT_SET = 8'h80;
  localparam logic [7:0] OFS_EVENT_CLR = 8'h84;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h88;
  localparam logic [7:0] OFS_LINK_CTRL = 8'h8C;
  localparam logic [7:0] OFS_PHY_DATA = 8'h90;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h94;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h98;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h9C;

  // Event bit positions
  localparam int EV_SOFT = 29;
  localparam int EV_LATE_ACK = 27;
  localparam int EV_PHY_BYTE = 26;
  localparam int EV_OVERRUN = 25;
  localparam int EV_FATAL = 24;
  localparam int EV_MISMATCH = 23;
  localparam int EV_MISSED = 22;
  localparam int EV_SIXTY_FOUR = 21;
  localparam int EV_NEW_CYCLE = 20;

  // Implemented event bits: 29, 27..20; reserved 31, 30, 28 read zero
  localparam logic [31:0] EV_IMPL_MASK = 32'h2FF0_0000;

  // Link control fields and the PHY data byte position
  localparam int LC_CYCLE_MASTER = 21;
  localparam int LC_LATE_ACK_EN = 29;
  localparam int PHY_BYTE_LSB = 16;

  // Reset values
  localparam logic [31:0] RST_FILTER = 32'h0000_0000;
  localparam logic [31:0] RST_EVENTS = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_LINK_CTRL = 32'h0000_0000;

  // Local interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_PKT_DROP = 0;
  localparam int IRQ_PKT_TAKEN = 1;
  localparam int IRQ_EVENT = 2;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lefcf_bus_t;

  // Hardware event sources, each a level whose rising edge counts
  typedef struct packed {
    logic rx_fifo_pending;
    logic phys_resp_busy;
    logic ack_tardy_sent;
    logic phy_byte_arrived;
    logic cycle_overrun_event;
    logic fatal_fault_event;
    logic cycle_time_mismatch_event;
    logic missed_cycle_event;
    logic missed_cycle_predicted;
  } lefcf_src_t;

  // Cycle timer view from the link
  typedef struct packed {
    logic [6:0] seconds_counter_field;
    logic [12:0] cycle_index_field;
  } lefcf_timer_t;

endpackage

// file: src/lefcf_top.sv
/*
  Event register, isochronous receive channel filter and local interrupt
  block. Assumes sources come from link logic on clk_in and software
  drives the plain register port with one-cycle strobes.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module lefcf_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire lefcf_pkg::lefcf_bus_t bus_in,
  output logic [31:0] rdata_out,
  input wire lefcf_pkg::lefcf_src_t src_in,
  input wire lefcf_pkg::lefcf_timer_t timer_in,
  input wire logic [7:0] phy_byte_in,
  input wire logic iso_pkt_valid_in,
  input wire logic [5:0] iso_pkt_channel_in,
  output logic iso_pkt_accept_out,
  output logic [31:0] iso_rx_channel_enable_out,
  output logic cycle_start_source_enable_out,
  output logic late_ack_event_enable_out,
  output logic context_irq_block_out,
  output logic [31:0] event_pending_out,
  output logic irq_out
);

  logic [31:0] filter_reg;
  logic [31:0] events_reg;
  logic [31:0] events_next;
  logic [31:0] mask_reg;
  logic [31:0] link_ctrl_reg;
  logic [31:0] link_ctrl_next;
  logic [7:0] phy_data_reg;
  logic [31:0] rdata_reg;
  logic [lefcf_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [lefcf_pkg::IRQ_W-1:0] irq_en_reg;
  logic [lefcf_pkg::IRQ_W-1:0] irq_hit;
  logic accept_reg;
  lefcf_pkg::lefcf_src_t src_prev_reg;
  lefcf_pkg::lefcf_timer_t timer_prev_reg;

  // Address decode
  wire wr_filter_set = bus_in.wr && bus_in.addr == lefcf_pkg::OFS_FILTER_SET;
  wire wr_filter_clr = bus_in.wr && bus_in.addr == lefcf_pkg::OFS_FILTER_CLR;
  wire wr_event_set = bus_in.wr && bus_in.addr == lefcf_pkg::OFS_EVENT_SET;
  wire wr_event_clr = bus_in.wr && bus_in.addr == lefcf_pkg::OFS_EVENT_CLR;
  wire wr_mask = bus_in.wr && bus_in.addr == lefcf_pkg::OFS_EVENT_MASK;
  wire wr_link = bus_in.wr && bus_in.addr == lefcf_pkg::OFS_LINK_CTRL;
  wire wr_irq_clr = bus_in.wr && bus_in.addr == lefcf_pkg::OFS_IRQ_CLEAR;
  wire wr_irq_en = bus_in.wr && bus_in.addr == lefcf_pkg::OFS_IRQ_ENABLE;

  // Rising edges of the hardware sources
  wire lefcf_pkg::lefcf_src_t src_rise = src_in & ~src_prev_reg;

  // Timer bit changes
  wire sec_bit6_chg = timer_in.seconds_counter_field[6]
    ^ timer_prev_reg.seconds_counter_field[6];
  wire cyc_bit0_chg = timer_in.cycle_index_field[0]
    ^ timer_prev_reg.cycle_index_field[0];

  wire late_ack_en = link_ctrl_reg[lefcf_pkg::LC_LATE_ACK_EN];
  wire cyc_master = link_ctrl_reg[lefcf_pkg::LC_CYCLE_MASTER];

  // Late-ack triggers gated by the enable; a trigger while disabled is lost
  wire late_ack_hit = late_ack_en && (src_rise.rx_fifo_pending
    || src_rise.phys_resp_busy || src_rise.ack_tardy_sent);

  // Overrun only meaningful while this node is cycle master
  wire overrun_hit = cyc_master && src_rise.cycle_overrun_event;

  // Early prediction folds into the same missed-cycle bit
  wire missed_hit = src_rise.missed_cycle_event
    || src_rise.missed_cycle_predicted;

  // Hardware event vector; bit 29 deliberately has no source
  logic [31:0] hw_set;
  always_comb
  begin
    hw_set = 32'h0000_0000;
    hw_set[lefcf_pkg::EV_LATE_ACK] = late_ack_hit;
    hw_set[lefcf_pkg::EV_PHY_BYTE] = src_rise.phy_byte_arrived;
    hw_set[lefcf_pkg::EV_OVERRUN] = overrun_hit;
    hw_set[lefcf_pkg::EV_FATAL] = src_rise.fatal_fault_event;
    hw_set[lefcf_pkg::EV_MISMATCH] =
      src_rise.cycle_time_mismatch_event;
    hw_set[lefcf_pkg::EV_MISSED] = missed_hit;
    hw_set[lefcf_pkg::EV_SIXTY_FOUR] = sec_bit6_chg;
    hw_set[lefcf_pkg::EV_NEW_CYCLE] = cyc_bit0_chg;
  end

  // Set beats clear, so an event in the clearing cycle survives
  wire [31:0] ev_set = hw_set | (wr_event_set ? bus_in.wdata : 32'h0);
  wire [31:0] ev_clr = wr_event_clr ? bus_in.wdata : 32'h0;
  assign events_next = ((events_reg & ~ev_clr) | ev_set)
    & lefcf_pkg::EV_IMPL_MASK;

  // Filter set/clear; set wins on a same-cycle conflict
  wire [31:0] filter_next = (filter_reg
    & ~(wr_filter_clr ? bus_in.wdata : 32'h0))
    | (wr_filter_set ? bus_in.wdata : 32'h0);

  // Link control: overrun drops cycle master, taking priority over software
  always_comb
  begin
    link_ctrl_next = link_ctrl_reg;
    if (wr_link)
      link_ctrl_next = bus_in.wdata;
    if (overrun_hit)
      link_ctrl_next[lefcf_pkg::LC_CYCLE_MASTER] = 1'b0;
  end

  // Masked event view used for reads only; the event interrupt takes unmasked new events
  wire [31:0] ev_masked = events_reg & mask_reg;

  // Channel filter check on a received isochronous packet
  wire pkt_ok = iso_pkt_valid_in && !iso_pkt_channel_in[5]
    && filter_reg[iso_pkt_channel_in[4:0]];

  // Local interrupt events
  always_comb
  begin
    irq_hit = '0;
    irq_hit[lefcf_pkg::IRQ_PKT_DROP] = iso_pkt_valid_in && !pkt_ok;
    irq_hit[lefcf_pkg::IRQ_PKT_TAKEN] = pkt_ok;
    irq_hit[lefcf_pkg::IRQ_EVENT] = |(ev_set & ~events_reg
      & lefcf_pkg::EV_IMPL_MASK);
  end

  // Read mux; unmapped and write-only offsets read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (bus_in.addr)
      lefcf_pkg::OFS_FILTER_SET,
      lefcf_pkg::OFS_FILTER_CLR: rd_mux = filter_reg;
      lefcf_pkg::OFS_EVENT_SET,
      lefcf_pkg::OFS_EVENT_CLR: rd_mux = ev_masked;
      lefcf_pkg::OFS_EVENT_MASK: rd_mux = mask_reg;
      lefcf_pkg::OFS_LINK_CTRL: rd_mux = link_ctrl_reg;
      lefcf_pkg::OFS_PHY_DATA: rd_mux =
        {8'h00, phy_data_reg, 16'h0000};
      lefcf_pkg::OFS_IRQ_STATUS: rd_mux =
        {{(32-lefcf_pkg::IRQ_W){1'b0}}, irq_stat_reg};
      lefcf_pkg::OFS_IRQ_ENABLE: rd_mux =
        {{(32-lefcf_pkg::IRQ_W){1'b0}}, irq_en_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Event, filter and control state
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      filter_reg <= lefcf_pkg::RST_FILTER;
      events_reg <= lefcf_pkg::RST_EVENTS;
      mask_reg <= lefcf_pkg::RST_MASK;
      link_ctrl_reg <= lefcf_pkg::RST_LINK_CTRL;
      src_prev_reg <= '0;
      timer_prev_reg <= '0;
    end
    else if (ce_in)
    begin
      filter_reg <= filter_next;
      events_reg <= events_next;
      link_ctrl_reg <= link_ctrl_next;
      src_prev_reg <= src_in;
      timer_prev_reg <= timer_in;
      if (wr_mask)
        mask_reg <= bus_in.wdata;
    end
  end

  // Captured PHY byte, held until the next arrival
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      phy_data_reg <= 8'h00;
    else if (ce_in && src_rise.phy_byte_arrived)
      phy_data_reg <= phy_byte_in;
  end

  // Local interrupt status: sticky, set beats write-one clear
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
    end
    else if (ce_in)
    begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_irq_clr
        ? bus_in.wdata[lefcf_pkg::IRQ_W-1:0] : '0)) | irq_hit;
      if (wr_irq_en)
        irq_en_reg <= bus_in.wdata[lefcf_pkg::IRQ_W-1:0];
    end
  end

  // Read data and packet accept, both one cycle after their request
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_reg <= 32'h0000_0000;
      accept_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      rdata_reg <= bus_in.rd ? rd_mux : 32'h0000_0000;
      accept_reg <= pkt_ok;
    end
  end

  assign rdata_out = rdata_reg;
  assign iso_pkt_accept_out = accept_reg;
  assign iso_rx_channel_enable_out = filter_reg;
  assign cycle_start_source_enable_out = cyc_master;
  assign late_ack_event_enable_out = late_ack_en;
  // Fatal fault blocks context interrupts while pending
  assign context_irq_block_out =
    events_reg[lefcf_pkg::EV_FATAL];
  assign event_pending_out = events_reg;
  assign irq_out = |(irq_stat_reg & irq_en_reg);

endmodule

// file: verif/lefcf_chk.sv
/*
  Checker for lefcf_top: filter, event and packet timing relations.
  Assumes one clock domain and sees only the top module's ports.
*/
`timescale 1ns/10ps
module lefcf_chk (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire lefcf_pkg::lefcf_bus_t bus_in,
  input wire logic [31:0] rdata_out,
  input wire lefcf_pkg::lefcf_src_t src_in,
  input wire logic iso_pkt_valid_in,
  input wire logic [5:0] iso_pkt_channel_in,
  input wire logic iso_pkt_accept_out,
  input wire logic [31:0] iso_rx_channel_enable_out,
  input wire logic cycle_start_source_enable_out,
  input wire logic late_ack_event_enable_out,
  input wire logic [31:0] event_pending_out
);
  // Decoded strobes; ce low means nothing is taken
  wire logic wr_ok = ce_in && bus_in.wr;
  wire logic rd_ok = ce_in && bus_in.rd;
  wire logic [7:0] ad = bus_in.addr;
  wire logic set_ev = wr_ok && ad == lefcf_pkg::OFS_EVENT_SET;
  wire logic [31:0] clr_bits =
    (wr_ok && ad == lefcf_pkg::OFS_EVENT_CLR) ? bus_in.wdata : 32'h0;
  wire logic [31:0] fil = iso_rx_channel_enable_out;
  wire logic acc_ok = ce_in && iso_pkt_valid_in &&
    !iso_pkt_channel_in[5] && fil[iso_pkt_channel_in[4:0]];

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Event and filter relations
  rsvd_zero_a: assert property (
    (event_pending_out & ~lefcf_pkg::EV_IMPL_MASK) == 32'h0)
    else $error("reserved event bit set");
  event_sticky_a: assert property (
    ($past(event_pending_out) & ~event_pending_out & ~$past(clr_bits))
    == 32'h0) else $error("event dropped without clear");
  soft_set_a: assert property (
    set_ev && bus_in.wdata[29] |=> event_pending_out[29])
    else $error("software event not set");
  filter_set_a: assert property (
    wr_ok && ad == lefcf_pkg::OFS_FILTER_SET |=>
    (fil & $past(bus_in.wdata)) == $past(bus_in.wdata))
    else $error("filter set lost");
  filter_clr_a: assert property (
    wr_ok && ad == lefcf_pkg::OFS_FILTER_CLR |=>
    (fil & $past(bus_in.wdata)) == 32'h0) else $error("filter clear lost");
  filter_read_a: assert property (
    rd_ok && (ad == lefcf_pkg::OFS_FILTER_SET ||
    ad == lefcf_pkg::OFS_FILTER_CLR) |=> rdata_out == $past(fil))
    else $error("filter read wrong");
  event_read_a: assert property (
    rd_ok && ad == lefcf_pkg::OFS_EVENT_SET |=>
    (rdata_out & ~$past(event_pending_out)) == 32'h0)
    else $error("event read not masked");
  pkt_accept_a: assert property (
    ce_in |=> iso_pkt_accept_out == $past(acc_ok))
    else $error("packet accept wrong");
  overrun_clr_a: assert property (
    ce_in && $past(ce_in) && $rose(src_in.cycle_overrun_event) &&
    cycle_start_source_enable_out |=> event_pending_out[25] &&
    !cycle_start_source_enable_out) else $error("overrun not handled");
  late_gate_a: assert property (
    $rose(event_pending_out[27]) |-> $past(late_ack_event_enable_out) ||
    $past(set_ev && bus_in.wdata[27])) else $error("late ack ungated");

  // Main scenarios reached
  cover property (iso_pkt_accept_out);
  cover property ($rose(event_pending_out[25]));
  cover property ($rose(event_pending_out[29]));
endmodule

bind lefcf_top lefcf_chk chk_u (.*);

// file: verif/lefcf_host.sv
/*
  Host software model: master of the lefcf_top register port.
  Assumes calls only after reset release; strobes last one cycle.
*/
`timescale 1ns/10ps
module lefcf_host (
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  output lefcf_pkg::lefcf_bus_t bus_out
);
  initial bus_out = '0;

  // Write strobe dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_out.wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_out.rd <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask
endmodule

// file: verif/tb_lefcf_top.sv
/*
  Bench for lefcf_top: filter, events, sources and interrupt.
  Assumes the host model and the bound checker; ce_in high except in the last step.
*/
`timescale 1ns/10ps
module tb_lefcf_top;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  lefcf_pkg::lefcf_bus_t bus;
  lefcf_pkg::lefcf_src_t src = '0;
  lefcf_pkg::lefcf_timer_t tmr = '0;
  logic [31:0] rdata, rv, chan, pend;
  logic [7:0] phy = 8'h00;
  logic pv = 1'b0;
  logic ce = 1'b1;
  logic [5:0] pch = 6'h00;
  logic acc, sce, lae, blk, irq;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int evb [9] = '{22, 22, 23, 24, 25, 26, 27, 27, 27};

  always #2.5 clk_in = ~clk_in;

  lefcf_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
    .bus_in(bus), .rdata_out(rdata), .src_in(src), .timer_in(tmr),
    .phy_byte_in(phy), .iso_pkt_valid_in(pv), .iso_pkt_channel_in(pch),
    .iso_pkt_accept_out(acc), .iso_rx_channel_enable_out(chan),
    .cycle_start_source_enable_out(sce), .late_ack_event_enable_out(lae),
    .context_irq_block_out(blk), .event_pending_out(pend), .irq_out(irq));
  lefcf_host host_u (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));

  // Comparison and closing report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bus and stimulus helpers
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    host_u.rd(a, rv);
    chk(rv, e);
  endtask
  task automatic pkt(input logic [5:0] ch, input logic e);
    @(posedge clk_in);
    pv <= 1'b1;
    pch <= ch;
    @(posedge clk_in);
    pv <= 1'b0;
    @(posedge clk_in);
    chk(32'(acc), 32'(e));
  endtask
  task automatic pulse(input int i);
    @(posedge clk_in);
    src <= lefcf_pkg::lefcf_src_t'(9'h001 << i);
    @(posedge clk_in);
    src <= '0;
  endtask

  // Hang guard: the whole run needs under two hundred cycles
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      summarize();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    rc(8'h78, 32'h0000_0000);
    host_u.wr(8'h78, 32'h8000_0001);
    pkt(6'h20, 1'b0);
    pkt(6'h00, 1'b1);
    host_u.wr(8'h7C, 32'h0000_0001);
    rc(8'h7C, 32'h8000_0000);
    pkt(6'h00, 1'b0);
    pkt(6'h1F, 1'b1);
    rc(8'h40, 32'h0000_0000);
    host_u.wr(8'h88, 32'hFFFF_FFFF);
    host_u.wr(8'h80, 32'hFFFF_FFFF);
    rc(8'h80, lefcf_pkg::EV_IMPL_MASK);
    host_u.wr(8'h84, 32'h0000_0000);
    rc(8'h84, lefcf_pkg::EV_IMPL_MASK);
    host_u.wr(8'h88, 32'h2000_0000);
    rc(8'h80, 32'h2000_0000);
    host_u.wr(8'h88, 32'hFFFF_FFFF);
    host_u.wr(8'h84, 32'hFFFF_FFFF);
    rc(8'h80, 32'h0000_0000);
    // Each source alone, late ack and cycle master enabled
    phy <= 8'hA5;
    for (int i = 0; i < 9; i++)
    begin
      host_u.wr(8'h8C, 32'h2020_0000);
      pulse(i);
      rc(8'h80, 32'h1 << evb[i]);
      host_u.wr(8'h84, 32'hFFFF_FFFF);
    end
    rc(8'h90, 32'h00A5_0000);
    host_u.wr(8'h8C, 32'h2020_0000);
    pulse(4);
    rc(8'h8C, 32'h2000_0000);
    host_u.wr(8'h84, 32'hFFFF_FFFF);
    host_u.wr(8'h8C, 32'h0000_0000);
    pulse(8);
    pulse(4);
    rc(8'h80, 32'h0000_0000);
    @(posedge clk_in);
    tmr.seconds_counter_field <= 7'h40;
    rc(8'h80, 32'h0020_0000);
    host_u.wr(8'h84, 32'hFFFF_FFFF);
    @(posedge clk_in);
    tmr.cycle_index_field <= 13'h0001;
    rc(8'h80, 32'h0010_0000);
    // Interrupt: raise, clear, raise again, mask
    host_u.wr(8'h9C, 32'h0000_0004);
    @(posedge clk_in);
    chk(32'(irq), 32'h1);
    host_u.wr(8'h98, 32'h0000_0004);
    @(posedge clk_in);
    chk(32'(irq), 32'h0);
    pulse(3);
    @(posedge clk_in);
    chk(32'(blk), 32'h1);
    chk(32'(irq), 32'h1);
    rc(8'h94, 32'h0000_0007);
    host_u.wr(8'h9C, 32'h0000_0000);
    @(posedge clk_in);
    chk(32'(irq), 32'h0);
    // Clock enable low: a filter write must not be taken
    ce <= 1'b0;
    host_u.wr(8'h78, 32'h0000_0002);
    ce <= 1'b1;
    rc(8'h78, 32'h8000_0000);
    summarize();
  end
endmodule
